// ---- optmod_pkg.sv ----
package optmod_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int CYC_PER_US = 1000000 / CLK_PERIOD_PS;

  localparam int T_OFF_US = 10;
  localparam int T_ON_MS = 1;
  localparam int T_INIT_MS = 300;
  localparam int T_FAULT_US = 100;
  localparam int T_RESET_US = 10;
  localparam int T_LOSS_US = 100;
  localparam int T_RATESEL_US = 10;
  localparam int LOS_FILT_US = 50;
  localparam int FAULT_FILT_US = 1;

  // longest times round down, least times round up
  localparam int T_OFF_CYC = T_OFF_US * CYC_PER_US;
  localparam int T_ON_CYC = T_ON_MS * 1000 * CYC_PER_US;
  localparam int T_INIT_CYC = T_INIT_MS * 1000 * CYC_PER_US;
  localparam int T_FAULT_CYC = T_FAULT_US * CYC_PER_US;
  localparam int T_RESET_CYC = (T_RESET_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_LOSS_CYC = T_LOSS_US * CYC_PER_US;
  localparam int T_RATESEL_CYC = T_RATESEL_US * CYC_PER_US;
  localparam int LOS_FILT_CYC = LOS_FILT_US * CYC_PER_US;
  localparam int FAULT_FILT_CYC = FAULT_FILT_US * CYC_PER_US;
  // sync stages plus output register around each filter decision
  localparam int PIPE_CYC = 4;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] INT_STAT_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS = 8'h0C;

  localparam int CTRL_SOFT_OFF_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;

  localparam int ST_FAULT_BIT = 0;
  localparam int ST_LOS_BIT = 1;
  localparam int ST_LASER_BIT = 2;
  localparam int ST_RATE_BIT = 3;
  localparam int ST_INIT_BIT = 4;

  localparam int EV_W = 4;
  localparam int EV_FAULT = 0;
  localparam int EV_LOS_ON = 1;
  localparam int EV_LOS_OFF = 2;
  localparam int EV_INIT_DONE = 3;
  localparam logic [EV_W-1:0] INT_RESET = 4'h0;

  typedef enum logic [1:0] {REG_CTRL, REG_STATUS, REG_INT_STAT, REG_INT_MASK} reg_sel_t;
  typedef enum {ST_INIT, ST_RUN, ST_FAULT} tx_state_t;

endpackage

// ---- qual_if.sv ----
`timescale 1ns/10ps
interface qual_if;
  logic raw;
  logic level;
  logic rise;
  logic fall;

  modport filt (input raw, output level, output rise, output fall);
  modport user (output raw, input level, input rise, input fall);
endinterface

// ---- qual_filter.sv ----
`timescale 1ns/10ps
module qual_filter #(
  parameter int CYCLES = 40
) (
  input wire logic clk,   // system clock
  input wire logic reset, // async, active high
  qual_if.filt q          // raw pin in, qualified level out
);
  import optmod_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);

  generate
    if (CYCLES < 2) begin : g_bad
      $error("qual_filter needs CYCLES of at least 2");
    end
  endgenerate

  logic meta;
  logic raw_s;
  logic level;
  logic [CW-1:0] cnt;
  logic next_level;
  logic [CW-1:0] next_cnt;

  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= 1'b0;
      raw_s <= 1'b0;
    end else begin
      meta <= q.raw;
      raw_s <= meta;
    end
  end

  // ----------------------------------------------------------------
  // qualifier: level moves only after CYCLES steady differing samples
  // ----------------------------------------------------------------
  always_comb begin
    next_level = level;
    next_cnt = '0;
    if (raw_s != level) begin
      if (cnt == CW'(CYCLES - 1)) begin
        next_level = raw_s;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level <= 1'b0;
      cnt <= '0;
    end else begin
      level <= next_level;
      cnt <= next_cnt;
    end
  end

  assign q.level = level;
  assign q.rise = next_level & ~level;
  assign q.fall = ~next_level & level;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_change_qualified: assert property ($changed(level) |-> $past(cnt) == CW'(CYCLES - 1))
    else $error("filter level changed before qualification");
  a_glitch_restart: assert property ((raw_s == level) |=> cnt == '0)
    else $error("filter count not restarted");

endmodule

// ---- optmod_ctrl.sv ----
`timescale 1ns/10ps
module optmod_ctrl #(
  parameter int INIT_CYCLES = optmod_pkg::T_INIT_CYC,     // power-on settling
  parameter int LOS_FILT_CYCLES = optmod_pkg::LOS_FILT_CYC, // loss qualification
  parameter int FAULT_FILT_CYCLES = optmod_pkg::FAULT_FILT_CYC // fault deglitch
) (
  input wire logic clk,               // 40 MHz
  input wire logic reset,             // async, active high
  input wire logic hsel,              // slave select
  input wire logic [31:0] haddr,      // byte address
  input wire logic [1:0] htrans,      // transfer type
  input wire logic hwrite,            // write when high
  input wire logic [2:0] hsize,       // word only
  input wire logic [31:0] hwdata,     // write data
  input wire logic hready,            // bus ready
  output logic hreadyout,             // never stalls
  output logic hresp,                 // always okay
  output logic [31:0] hrdata,         // read data
  input wire logic tx_disable_pin,    // laser-off request
  input wire logic rate_select_pin,   // bandwidth choice
  input wire logic loss_detect,       // receiver loss comparator
  input wire logic fault_detect,      // laser fault comparator
  output logic laser_enable,          // transmitter on
  output logic rx_bw_high,            // receiver bandwidth choice
  output logic rx_los,                // receive signal lost
  output logic tx_fault_o,            // open-drain data, always low
  output logic tx_fault_oe_n,         // low while pulling fault pin low
  output logic irq                    // level interrupt
);
  import optmod_pkg::*;

  localparam int IW = $clog2(INIT_CYCLES + 1);
  localparam int RW = $clog2(T_RESET_CYC + 1);

  generate
    if (INIT_CYCLES < 2 || INIT_CYCLES > T_INIT_CYC) begin : g_bad_init
      $error("INIT_CYCLES out of range");
    end
    if (LOS_FILT_CYCLES + PIPE_CYC > T_LOSS_CYC) begin : g_bad_los
      $error("LOS_FILT_CYCLES too long for loss timing");
    end
    if (FAULT_FILT_CYCLES + PIPE_CYC > T_FAULT_CYC) begin : g_bad_fault
      $error("FAULT_FILT_CYCLES too long for fault timing");
    end
  endgenerate

  function automatic reg_sel_t reg_decode(input logic [31:0] a);
    case (a[7:0])
      CTRL_OFS: reg_decode = REG_CTRL;
      STATUS_OFS: reg_decode = REG_STATUS;
      INT_STAT_OFS: reg_decode = REG_INT_STAT;
      default: reg_decode = REG_INT_MASK;
    endcase
  endfunction

  function automatic logic reg_mapped(input logic [31:0] a);
    reg_mapped = (a[31:8] == 24'h000000) &&
                 (a[7:0] == CTRL_OFS || a[7:0] == STATUS_OFS ||
                  a[7:0] == INT_STAT_OFS || a[7:0] == INT_MASK_OFS);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and qualifiers
  // ----------------------------------------------------------------
  logic dis_meta;
  logic dis_sync;
  logic rate_meta;
  logic rate_sync;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dis_meta <= 1'b1;
      dis_sync <= 1'b1;
      rate_meta <= 1'b0;
      rate_sync <= 1'b0;
    end else begin
      dis_meta <= tx_disable_pin;
      dis_sync <= dis_meta;
      rate_meta <= rate_select_pin;
      rate_sync <= rate_meta;
    end
  end

  qual_if los_q ();
  qual_if fault_q ();
  assign los_q.raw = loss_detect;
  assign fault_q.raw = fault_detect;

  qual_filter #(.CYCLES(LOS_FILT_CYCLES)) u_los_filt (
    .clk(clk),
    .reset(reset),
    .q(los_q.filt)
  );

  qual_filter #(.CYCLES(FAULT_FILT_CYCLES)) u_fault_filt (
    .clk(clk),
    .reset(reset),
    .q(fault_q.filt)
  );

  // ----------------------------------------------------------------
  // transmitter state
  // ----------------------------------------------------------------
  tx_state_t state;
  tx_state_t next_state;
  logic [IW-1:0] init_cnt;
  logic [IW-1:0] next_init_cnt;
  logic [RW-1:0] dis_cnt;
  logic [RW-1:0] next_dis_cnt;
  logic fault_flag;
  logic next_fault_flag;
  logic next_laser;
  logic next_bw;
  logic next_los;
  logic ctrl_soft_off;
  logic dis_eff;
  logic reset_held;

  assign dis_eff = dis_sync | ctrl_soft_off;
  // the fault reset is a pin level only; software cannot clear a laser fault
  assign reset_held = dis_sync && (dis_cnt == RW'(T_RESET_CYC - 1));

  always_comb begin
    next_state = state;
    next_init_cnt = init_cnt;
    next_fault_flag = fault_flag;
    next_laser = 1'b0;
    next_bw = rate_sync;
    next_los = los_q.level;
    next_dis_cnt = '0;
    if (dis_sync) begin
      next_dis_cnt = (dis_cnt == RW'(T_RESET_CYC)) ? dis_cnt : dis_cnt + 1'b1;
    end
    case (state)
      ST_INIT: begin
        next_fault_flag = 1'b0;
        if (init_cnt == IW'(INIT_CYCLES - 1)) begin
          next_state = ST_RUN;
        end else begin
          next_init_cnt = init_cnt + 1'b1;
        end
      end
      ST_RUN: begin
        if (fault_q.level) begin
          next_state = ST_FAULT;
          next_fault_flag = 1'b1;
        end else begin
          next_laser = ~dis_eff;
        end
      end
      ST_FAULT: begin
        next_fault_flag = 1'b1;
        if (reset_held) begin
          next_state = ST_INIT;
          next_init_cnt = '0;
        end
      end
      default: begin
        next_state = ST_INIT;
        next_init_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_INIT;
      init_cnt <= '0;
      dis_cnt <= '0;
      fault_flag <= 1'b0;
      laser_enable <= 1'b0;
      rx_bw_high <= 1'b0;
      rx_los <= 1'b0;
    end else begin
      state <= next_state;
      init_cnt <= next_init_cnt;
      dis_cnt <= next_dis_cnt;
      fault_flag <= next_fault_flag;
      laser_enable <= next_laser;
      rx_bw_high <= next_bw;
      rx_los <= next_los;
    end
  end

  // open drain: released (pulled high) while the fault is latched
  assign tx_fault_o = 1'b0;
  assign tx_fault_oe_n = fault_flag;

  // ----------------------------------------------------------------
  // bus slave and registers
  // ----------------------------------------------------------------
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] int_stat;
  logic [EV_W-1:0] next_int_stat;
  logic [EV_W-1:0] int_mask;
  logic [EV_W-1:0] next_int_mask;
  logic next_ctrl_soft_off;
  logic dp_wr;
  logic next_dp_wr;
  reg_sel_t dp_sel;
  reg_sel_t next_dp_sel;
  logic [31:0] next_hrdata;
  logic ap_take;
  logic rd_clear;
  logic [31:0] status_word;

  assign ap_take = hsel && htrans[1] && hready;
  assign rd_clear = ap_take && !hwrite && reg_mapped(haddr) &&
                    reg_decode(haddr) == REG_INT_STAT;

  assign events[EV_FAULT] = (state == ST_RUN) && (next_state == ST_FAULT);
  assign events[EV_LOS_ON] = los_q.rise;
  assign events[EV_LOS_OFF] = los_q.fall;
  assign events[EV_INIT_DONE] = (state == ST_INIT) && (next_state == ST_RUN);

  always_comb begin
    status_word = '0;
    status_word[ST_FAULT_BIT] = fault_flag;
    status_word[ST_LOS_BIT] = rx_los;
    status_word[ST_LASER_BIT] = laser_enable;
    status_word[ST_RATE_BIT] = rx_bw_high;
    status_word[ST_INIT_BIT] = (state == ST_INIT);
  end

  always_comb begin
    next_dp_wr = ap_take && hwrite && reg_mapped(haddr);
    next_dp_sel = ap_take ? reg_decode(haddr) : dp_sel;
    next_hrdata = hrdata;
    next_ctrl_soft_off = ctrl_soft_off;
    next_int_mask = int_mask;
    // set wins over the read clear in the same cycle
    next_int_stat = (rd_clear ? INT_RESET : int_stat) | events;
    if (ap_take && !hwrite) begin
      next_hrdata = '0;
      if (reg_mapped(haddr)) begin
        case (reg_decode(haddr))
          REG_CTRL: next_hrdata[CTRL_SOFT_OFF_BIT] = ctrl_soft_off;
          REG_STATUS: next_hrdata = status_word;
          REG_INT_STAT: next_hrdata[EV_W-1:0] = int_stat;
          REG_INT_MASK: next_hrdata[EV_W-1:0] = int_mask;
          default: next_hrdata = '0;
        endcase
      end
    end
    if (dp_wr) begin
      case (dp_sel)
        REG_CTRL: next_ctrl_soft_off = hwdata[CTRL_SOFT_OFF_BIT];
        REG_INT_MASK: next_int_mask = hwdata[EV_W-1:0];
        default: next_int_mask = int_mask;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dp_wr <= 1'b0;
      dp_sel <= REG_CTRL;
      hrdata <= '0;
      ctrl_soft_off <= CTRL_RESET;
      int_mask <= INT_RESET;
      int_stat <= INT_RESET;
    end else begin
      dp_wr <= next_dp_wr;
      dp_sel <= next_dp_sel;
      hrdata <= next_hrdata;
      ctrl_soft_off <= next_ctrl_soft_off;
      int_mask <= next_int_mask;
      int_stat <= next_int_stat;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(int_stat & int_mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_fault_latched;
    state == ST_FAULT && fault_flag;
  endsequence

  sequence s_reset_reached;
    dis_sync && dis_cnt == RW'(T_RESET_CYC - 1);
  endsequence

  a_laser_off_fast: assert property ($rose(dis_sync) |=> !laser_enable)
    else $error("laser not off after disable");
  a_laser_on_bound: assert property ((state == ST_RUN && !fault_q.level && !dis_eff)
                                     |=> laser_enable)
    else $error("laser not restored");
  a_init_clears: assert property ((state == ST_INIT) |=>
                                  !fault_flag ##0 init_cnt < IW'(INIT_CYCLES))
    else $error("init did not clear fault or overran");
  a_fault_raise: assert property ((state == ST_RUN && fault_q.level) |=> fault_flag ##1 irq
                                  || !int_mask[EV_FAULT])
    else $error("fault flag not raised");
  a_fault_reset: assert property (s_fault_latched ##0 s_reset_reached |=> state == ST_INIT)
    else $error("held disable did not reset fault");
  a_fault_sticky: assert property ((s_fault_latched ##0 !reset_held) |=> fault_flag)
    else $error("fault flag dropped early");
  a_los_follow: assert property ($changed(los_q.level) |=> rx_los == $past(los_q.level))
    else $error("loss output lags qualified level");
  a_rate_follow: assert property ($changed(rate_sync) |=> rx_bw_high == $past(rate_sync))
    else $error("bandwidth not following select");
  a_int_sticky: assert property ((events[EV_LOS_OFF] && rd_clear) |=> int_stat[EV_LOS_OFF])
    else $error("loss release event lost to clear");

endmodule

// ---- host_model.sv ----
`timescale 1ns/10ps
module host_model (
  input wire logic clk,           // bench clock
  input wire logic tx_fault_o,    // module fault data
  input wire logic tx_fault_oe_n, // module fault enable, low drives
  output logic tx_disable_pin,    // laser-off request
  output logic rate_select_pin,   // bandwidth choice
  output logic tx_fault_pin       // fault wire as the host sees it
);
  // ------------------------------------------------
  // fault wire: open drain with host pull-up
  // ------------------------------------------------
  assign tx_fault_pin = tx_fault_oe_n ? 1'b1 : tx_fault_o;

  initial begin
    tx_disable_pin = 1'b1; // pulled up, so open means off
    rate_select_pin = 1'b0;
  end

  // ------------------------------------------------
  // pin drivers
  // ------------------------------------------------
  // the management clock is never toggled by this host
  task automatic set_pins(input logic dis, input logic rate);
    @(posedge clk);
    tx_disable_pin <= dis;
    rate_select_pin <= rate;
  endtask

  // holds under the reset time must leave a latched fault alone
  task automatic pulse_disable(input int cycles);
    @(posedge clk);
    tx_disable_pin <= 1'b1;
    repeat (cycles) @(posedge clk);
    tx_disable_pin <= 1'b0;
  endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
  import optmod_pkg::*;
  localparam int INIT_C = 20;
  localparam int LOSF_C = 8;
  localparam int FLTF_C = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic loss_detect = 1'b0;
  logic fault_detect = 1'b0;
  logic hready, hreadyout, hresp, laser_enable, rx_bw_high, rx_los, irq;
  logic tx_fault_o, tx_fault_oe_n, tx_disable_pin, rate_select_pin, tx_fault_pin;
  logic [31:0] hrdata;
  logic [31:0] lfsr = 32'hFF65B597;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  // model state
  int m_ctrl = 0, m_mask = 0, m_ev = 0, m_fault = 0, m_los = 0, m_bw = 0, m_off = 1, m_init = 1;

  assign hready = hreadyout;

  optmod_ctrl #(.INIT_CYCLES(INIT_C), .LOS_FILT_CYCLES(LOSF_C), .FAULT_FILT_CYCLES(FLTF_C))
    optmod_ctrl_inst (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .tx_disable_pin(tx_disable_pin),
    .rate_select_pin(rate_select_pin), .loss_detect(loss_detect), .fault_detect(fault_detect),
    .laser_enable(laser_enable), .rx_bw_high(rx_bw_high), .rx_los(rx_los),
    .tx_fault_o(tx_fault_o), .tx_fault_oe_n(tx_fault_oe_n), .irq(irq));

  host_model host_model_inst (.clk(clk), .tx_fault_o(tx_fault_o),
    .tx_fault_oe_n(tx_fault_oe_n), .tx_disable_pin(tx_disable_pin),
    .rate_select_pin(rate_select_pin), .tx_fault_pin(tx_fault_pin));

  initial begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int exp_laser();
    return (m_init == 0 && m_fault == 0 && m_off == 0 && m_ctrl == 0);
  endfunction

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      CTRL_OFS: return 32'(m_ctrl);
      STATUS_OFS: return 32'(m_init * 16 + m_bw * 8 + exp_laser() * 4 + m_los * 2 + m_fault);
      INT_STAT_OFS: return 32'(m_ev);
      INT_MASK_OFS: return 32'(m_mask);
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic sig(input int w);
    case (w)
      0: return laser_enable;
      1: return rx_los;
      2: return rx_bw_high;
      default: return tx_fault_pin;
    endcase
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // ------------------------------------------------
  // bus master: address phase, then data phase
  // ------------------------------------------------
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
    if (a == CTRL_OFS) m_ctrl = int'(d[0]);
    if (a == INT_MASK_OFS) m_mask = int'(d[3:0]);
  endtask

  // reads of the event register clear it in the model too
  task automatic rd_chk(input logic [7:0] a);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    check("read data", q, exp_rd(a));
    check("hresp", 32'(hresp), 32'h0);
    check("hreadyout", 32'(hreadyout), 32'h1);
    if (a == INT_STAT_OFS) m_ev = 0;
  endtask

  task automatic check_all();
    check("laser_enable", laser_enable, 32'(exp_laser()));
    check("rx_los", rx_los, 32'(m_los));
    check("rx_bw_high", rx_bw_high, 32'(m_bw));
    check("tx_fault_pin", tx_fault_pin, 32'(m_fault));
    check("irq", irq, 32'((m_ev & m_mask) != 0));
  endtask

  // bounded wait; the bound is the documented response time
  task automatic wait_for(input int w, input logic v, input int lim);
    n = 0;
    while (sig(w) !== v && n <= lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("response delay", 32'(n <= lim), 32'h1);
  endtask

  task automatic drive(input logic loss, input logic fault);
    @(posedge clk);
    loss_detect <= loss;
    fault_detect <= fault;
  endtask

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    check_all();
    rd_chk(STATUS_OFS);
    rd_chk(CTRL_OFS);
    rd_chk(INT_MASK_OFS);
    host_model_inst.set_pins(1'b0, 1'b0);
    wait_for(0, 1'b1, INIT_C + T_ON_CYC);
    m_init = 0;
    m_off = 0;
    m_ev = 8;
    settle();
    check_all();
    for (int i = 0; i < 6; i++) begin
      lfsr = next_rand(lfsr);
      wr(INT_MASK_OFS, lfsr);
      rd_chk(INT_MASK_OFS);
      settle();
      check_all();
    end
    rd_chk(INT_STAT_OFS);
    rd_chk(INT_STAT_OFS);
    settle();
    check_all();
    for (int v = 1; v >= 0; v--) begin
      host_model_inst.set_pins(1'b0, v[0]);
      wait_for(2, v[0], T_RATESEL_CYC);
      m_bw = v;
      settle();
      rd_chk(STATUS_OFS);
    end
    host_model_inst.set_pins(1'b1, 1'b0);
    wait_for(0, 1'b0, T_OFF_CYC);
    m_off = 1;
    settle();
    check_all();
    host_model_inst.set_pins(1'b0, 1'b0);
    wait_for(0, 1'b1, T_ON_CYC);
    m_off = 0;
    wr(CTRL_OFS, 32'h1);
    settle();
    check_all();
    wr(CTRL_OFS, 32'h0);
    wait_for(0, 1'b1, T_ON_CYC);
    wr(8'h10, 32'hFFFFFFFF);
    wr(STATUS_OFS, 32'hFFFFFFFF);
    rd_chk(8'h10);
    rd_chk(STATUS_OFS);
    wr(INT_MASK_OFS, 32'h2);
    drive(1'b1, 1'b0);
    repeat (LOSF_C - 4) @(posedge clk);
    loss_detect <= 1'b0;
    repeat (LOSF_C + 6) @(posedge clk);
    #1;
    check_all();
    drive(1'b1, 1'b0);
    wait_for(1, 1'b1, T_LOSS_CYC);
    m_los = 1;
    m_ev = 2;
    settle();
    check_all();
    rd_chk(INT_STAT_OFS);
    settle();
    check_all();
    drive(1'b0, 1'b0);
    wait_for(1, 1'b0, T_LOSS_CYC);
    m_los = 0;
    m_ev = 4;
    settle();
    rd_chk(INT_STAT_OFS);
    drive(1'b0, 1'b1);
    wait_for(3, 1'b1, T_FAULT_CYC);
    m_fault = 1;
    m_ev = 1;
    settle();
    check_all();
    rd_chk(STATUS_OFS);
    drive(1'b0, 1'b0);
    host_model_inst.pulse_disable(T_RESET_CYC / 4);
    settle();
    check_all();
    host_model_inst.pulse_disable(T_RESET_CYC + 10);
    wait_for(0, 1'b1, INIT_C + T_ON_CYC);
    m_fault = 0;
    m_ev = 9;
    settle();
    check_all();
    wr(INT_STAT_OFS, 32'h0);
    rd_chk(INT_STAT_OFS);
    // power cycle in mid-run: all state back to reset, init runs again
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    m_ctrl = 0;
    m_mask = 0;
    m_ev = 0;
    m_init = 1;
    #1;
    check_all();
    rd_chk(STATUS_OFS);
    rd_chk(INT_MASK_OFS);
    wait_for(0, 1'b1, INIT_C + T_ON_CYC);
    m_init = 0;
    m_ev = 8;
    settle();
    check_all();
    rd_chk(INT_STAT_OFS);
    wrap_up();
  end
endmodule
